// [src/ctk_map.svh]
// Register map, field positions, reset values and timing counts of the touch controller
// ----------------------------------------------------------------------------
// Function
// - Supply bit picks bypass chip supply or internal regulator for touch module.
// - In regulator mode a second bit picks one of two regulator levels.
// - Two-bit pin field assigns sampling capacitor function instead of port function.
// - Command 0x10 starts conversion, first discharging the capacitor automatically.
// - Automatic discharge lasts 32, 64 or 128 touch clocks per settings field.
// - Command 0x30 holds discharge; a later start continues the conversion.
// - Command 0x00 aborts any conversion in progress.
// - After discharge, charge one step per touch clock and count those clocks.
// - Charging and counting stop by themselves when threshold is reached.
// - Charging stopped is shown in bit 3 of the interrupt request register.
// - Three-bit settings field selects threshold 0.8 down to 0.2 of supply.
// - Final count readable through high byte and low byte registers.
// - Counter overflow sets overflow flag and counting continues from zero.
// ----------------------------------------------------------------------------
`ifndef CTK_MAP_SVH
`define CTK_MAP_SVH

`define CTK_ADDR_W       6
`define CTK_OFF_PWR      6'h00
`define CTK_OFF_MISC     6'h04
`define CTK_OFF_PAD      6'h08
`define CTK_OFF_CMD      6'h0c
`define CTK_OFF_SET      6'h10
`define CTK_OFF_IRQ      6'h14
`define CTK_OFF_CNTH     6'h18
`define CTK_OFF_CNTL     6'h1c
`define CTK_OFF_MASK     6'h20

`define CTK_PWR_BYPASS   2
`define CTK_PWR_LEVEL    3
`define CTK_IRQ_DONE     3
`define CTK_IRQ_OVF      6
`define CTK_IRQ_BITS     8'h48

`define CTK_CMD_ABORT    8'h00
`define CTK_CMD_START    8'h10
`define CTK_CMD_HOLD     8'h30

`define CTK_PAD_W        13
`define CTK_PAD_RST      13'h0000
`define CTK_SET_RST      5'h00
`define CTK_DIS_BASE     8'h20

`define CTK_TICK_DIV     4'h4
`endif

// [src/ctk_pkg.sv]
// Types shared by the touch controller
package ctk_pkg;
  typedef enum logic [1:0] {
    CTK_IDLE = 2'b00,
    CTK_DIS  = 2'b01,
    CTK_CHG  = 2'b11,
    CTK_HOLD = 2'b10
  } ctk_state_t;
endpackage

// [src/ctk_top.sv]
// Capacitive touch controller with Avalon-MM register slave
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ctk_map.svh"

module ctk_top (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [`CTK_ADDR_W-1:0]  avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic [31:0]                  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire logic                    thr_reached_i,
  output logic                         regulator_mode_o,
  output logic                         regulator_level_o,
  output logic [1:0]                   cs_pin_sel_o,
  output logic [`CTK_PAD_W-1:0]        touch_pad_select_o,
  output logic [2:0]                   threshold_sel_o,
  output logic                         discharge_o,
  output logic                         charge_o,
  output logic                         irq_o
);
  import ctk_pkg::*;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Discharge length in touch clocks; both upper codes give the longest
  function automatic logic [7:0] dis_len(input logic [1:0] sel);
    logic [7:0] len;
    len = `CTK_DIS_BASE;
    if (sel == 2'd1) begin
      len = `CTK_DIS_BASE << 1;
    end else if (sel[1]) begin
      len = `CTK_DIS_BASE << 2;
    end
    return len;
  endfunction

  function automatic logic hit(input logic [`CTK_ADDR_W-1:0] a, input logic [`CTK_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------------
  logic        wait_ff;
  logic        nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        acc_wr;
  logic        acc_rd;
  logic        be0;

  // Every access takes one wait state; read data is captured while waitrequest is high
  assign acc_wr = avs_write_i & ~wait_ff;
  assign acc_rd = avs_read_i & ~wait_ff;
  assign be0    = avs_byteenable_i[0];

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0]            pwr_ff;
  logic [7:0]            nxt_pwr;
  logic [1:0]            misc_ff;
  logic [1:0]            nxt_misc;
  logic [`CTK_PAD_W-1:0] pad_ff;
  logic [`CTK_PAD_W-1:0] nxt_pad;
  logic [4:0]            set_ff;
  logic [4:0]            nxt_set;
  logic [7:0]            irq_ff;
  logic [7:0]            nxt_irq;
  logic [7:0]            mask_ff;
  logic [7:0]            nxt_mask;
  logic                  irq_out_ff;
  logic                  nxt_irq_out;

  // ----------------------------------------------------------------------------
  // Conversion state
  // ----------------------------------------------------------------------------
  ctk_state_t  state_ff;
  ctk_state_t  nxt_state;
  logic [3:0]  div_ff;
  logic [3:0]  nxt_div;
  logic [7:0]  dis_ff;
  logic [7:0]  nxt_dis;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        tick;
  logic        cmd_wr;
  logic        set_done;
  logic        set_ovf;

  assign tick   = div_ff == `CTK_TICK_DIV - 4'h1;
  assign cmd_wr = acc_wr & be0 & hit(avs_address_i, `CTK_OFF_CMD);

  always_comb begin
    nxt_wait = ~(avs_read_i | avs_write_i) | ~wait_ff;
    nxt_rdata = 32'h0000_0000;
    if (avs_read_i & wait_ff) begin
      case (avs_address_i)
        `CTK_OFF_PWR:  nxt_rdata[7:0] = pwr_ff;
        `CTK_OFF_MISC: nxt_rdata[2:1] = misc_ff;
        `CTK_OFF_PAD:  nxt_rdata[`CTK_PAD_W-1:0] = pad_ff;
        `CTK_OFF_SET:  nxt_rdata[4:0] = set_ff;
        `CTK_OFF_IRQ:  nxt_rdata[7:0] = irq_ff;
        `CTK_OFF_CNTH: nxt_rdata[7:0] = cnt_ff[15:8];
        `CTK_OFF_CNTL: nxt_rdata[7:0] = cnt_ff[7:0];
        `CTK_OFF_MASK: nxt_rdata[7:0] = mask_ff;
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end else if (~wait_ff) begin
      nxt_rdata = rdata_ff;
    end
  end

  always_comb begin
    nxt_pwr  = pwr_ff;
    nxt_misc = misc_ff;
    nxt_pad  = pad_ff;
    nxt_set  = set_ff;
    nxt_mask = mask_ff;
    nxt_irq  = irq_ff;
    if (acc_wr & be0) begin
      if (hit(avs_address_i, `CTK_OFF_PWR)) begin
        nxt_pwr = avs_writedata_i[7:0];
      end
      if (hit(avs_address_i, `CTK_OFF_MISC)) begin
        nxt_misc = avs_writedata_i[2:1];
      end
      if (hit(avs_address_i, `CTK_OFF_SET)) begin
        nxt_set = avs_writedata_i[4:0];
      end
      if (hit(avs_address_i, `CTK_OFF_MASK)) begin
        nxt_mask = avs_writedata_i[7:0] & `CTK_IRQ_BITS;
      end
      if (hit(avs_address_i, `CTK_OFF_IRQ)) begin
        nxt_irq = irq_ff & avs_writedata_i[7:0];
      end
      if (hit(avs_address_i, `CTK_OFF_PAD)) begin
        nxt_pad[7:0] = avs_writedata_i[7:0];
      end
    end
    if (acc_wr & avs_byteenable_i[1] & hit(avs_address_i, `CTK_OFF_PAD)) begin
      nxt_pad[`CTK_PAD_W-1:8] = avs_writedata_i[`CTK_PAD_W-1:8];
    end
    // Clear only what the read returned, so an event landing in the wait state survives
    if (acc_rd & hit(avs_address_i, `CTK_OFF_IRQ)) begin
      nxt_irq = irq_ff & ~rdata_ff[7:0];
    end
    if (cmd_wr & (avs_writedata_i[7:0] == `CTK_CMD_START)) begin
      nxt_irq[`CTK_IRQ_DONE] = 1'b0;
    end
    if (set_done) begin
      nxt_irq[`CTK_IRQ_DONE] = 1'b1;
    end
    if (set_ovf) begin
      nxt_irq[`CTK_IRQ_OVF] = 1'b1;
    end
    nxt_irq_out = |(nxt_irq & mask_ff);
  end

  // ----------------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_dis   = dis_ff;
    nxt_cnt   = cnt_ff;
    nxt_div   = tick ? 4'h0 : div_ff + 4'h1;
    set_done  = 1'b0;
    set_ovf   = 1'b0;
    case (state_ff)
      CTK_DIS: begin
        if (tick) begin
          nxt_dis = dis_ff - 8'h01;
          if (dis_ff == 8'h01) begin
            nxt_state = CTK_CHG;
          end
        end
      end
      CTK_CHG: begin
        if (tick) begin
          nxt_cnt = cnt_ff + 16'h0001;
          set_ovf = cnt_ff == 16'hffff;
        end
        // A touch clock tick in the same cycle as the threshold is seen still counts
        if (thr_reached_i) begin
          nxt_state = CTK_IDLE;
          set_done  = 1'b1;
        end
      end
      CTK_HOLD: nxt_state = CTK_HOLD;
      CTK_IDLE: nxt_state = CTK_IDLE;
      default:  nxt_state = CTK_IDLE;
    endcase
    if (cmd_wr) begin
      case (avs_writedata_i[7:0])
        `CTK_CMD_START: begin
          nxt_cnt  = 16'h0000;
          nxt_div  = 4'h0;
          set_done = 1'b0;
          set_ovf  = 1'b0;
          if (state_ff == CTK_HOLD) begin
            nxt_state = CTK_CHG;
          end else begin
            nxt_state = CTK_DIS;
            nxt_dis   = dis_len(set_ff[1:0]);
          end
        end
        `CTK_CMD_HOLD: begin
          nxt_state = CTK_HOLD;
          set_done  = 1'b0;
          set_ovf   = 1'b0;
        end
        `CTK_CMD_ABORT: begin
          nxt_state = CTK_IDLE;
          set_done  = 1'b0;
          set_ovf   = 1'b0;
        end
        default: nxt_state = nxt_state;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Phase outputs
  // ----------------------------------------------------------------------------
  logic dis_out_ff;
  logic nxt_dis_out;
  logic chg_out_ff;
  logic nxt_chg_out;

  // Decoded from the next state so the pins switch together with the state
  always_comb begin
    nxt_dis_out = (nxt_state == CTK_DIS) || (nxt_state == CTK_HOLD);
    nxt_chg_out = nxt_state == CTK_CHG;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dis_out_ff <= 1'b0;
      chg_out_ff <= 1'b0;
    end else begin
      dis_out_ff <= nxt_dis_out;
      chg_out_ff <= nxt_chg_out;
    end
  end

  // ----------------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_ff    <= 1'b1;
      rdata_ff   <= 32'h0000_0000;
      pwr_ff     <= 8'h00;
      misc_ff    <= 2'h0;
      pad_ff     <= `CTK_PAD_RST;
      set_ff     <= `CTK_SET_RST;
      irq_ff     <= 8'h00;
      mask_ff    <= 8'h00;
      irq_out_ff <= 1'b0;
      state_ff   <= CTK_IDLE;
      div_ff     <= 4'h0;
      dis_ff     <= 8'h00;
      cnt_ff     <= 16'h0000;
    end else begin
      wait_ff    <= nxt_wait;
      rdata_ff   <= nxt_rdata;
      pwr_ff     <= nxt_pwr;
      misc_ff    <= nxt_misc;
      pad_ff     <= nxt_pad;
      set_ff     <= nxt_set;
      irq_ff     <= nxt_irq;
      mask_ff    <= nxt_mask;
      irq_out_ff <= nxt_irq_out;
      state_ff   <= nxt_state;
      div_ff     <= nxt_div;
      dis_ff     <= nxt_dis;
      cnt_ff     <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign avs_readdata_o     = rdata_ff;
  assign avs_waitrequest_o  = wait_ff;
  assign regulator_mode_o   = pwr_ff[`CTK_PWR_BYPASS];
  assign regulator_level_o  = pwr_ff[`CTK_PWR_LEVEL];
  assign cs_pin_sel_o       = misc_ff;
  assign touch_pad_select_o = pad_ff;
  assign threshold_sel_o    = set_ff[4:2];
  assign discharge_o        = dis_out_ff;
  assign charge_o           = chg_out_ff;
  assign irq_o              = irq_out_ff;

endmodule
`default_nettype wire

// [verif/ctk_chk.sv]
// Port assertions for the touch controller
`timescale 1ns/1ps
`default_nettype none
`include "ctk_map.svh"
module ctk_chk (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic [`CTK_ADDR_W-1:0] avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [31:0]            avs_writedata_i,
  input wire logic [3:0]             avs_byteenable_i,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   thr_reached_i,
  input wire logic                   discharge_o,
  input wire logic                   charge_o,
  input wire logic                   irq_o
);
  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic       held_ff;
  logic       nxt_held;
  logic       cmd_w;
  logic [7:0] cmd;
  assign cmd   = avs_writedata_i[7:0];
  assign cmd_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == `CTK_OFF_CMD;
  // Discharge length so far, and whether a manual hold is in play
  always_comb begin
    nxt_cnt  = discharge_o ? cnt_ff + 10'h001 : (charge_o ? cnt_ff : 10'h000);
    nxt_held = (cmd_w && cmd == `CTK_CMD_HOLD) || (held_ff && (discharge_o || charge_o));
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= 10'h000;
      held_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      held_ff <= nxt_held;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  ans_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
  phase_excl_a: assert property (!(discharge_o && charge_o)) else $error("both phases active");
  thr_stop_a: assert property (charge_o && thr_reached_i && !cmd_w |=> !charge_o)
    else $error("charge kept after threshold");
  start_dis_a: assert property (cmd_w && cmd == `CTK_CMD_START && !discharge_o && !charge_o
    |=> discharge_o && !charge_o) else $error("start without discharge");
  hold_dis_a: assert property (cmd_w && cmd == `CTK_CMD_HOLD |=> (discharge_o && !charge_o) [*4])
    else $error("hold not discharging");
  abort_idle_a: assert property (cmd_w && cmd == `CTK_CMD_ABORT |=> !discharge_o && !charge_o)
    else $error("abort ignored");
  dis_len_a: assert property ($rose(charge_o) && !held_ff |-> cnt_ff inside {10'h080, 10'h100, 10'h200})
    else $error("discharge length wrong");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(charge_o, 2) || $past(avs_write_i, 2))
    else $error("irq without cause");
  cover property ($rose(charge_o));
  cover property ($rose(irq_o));
  cover property (cmd_w && cmd == `CTK_CMD_HOLD);
endmodule
bind ctk_top ctk_chk i_chk (.*);
`default_nettype wire

// [verif/ctk_pad_model.sv]
// Pad and sampling capacitor model: comparator rises after a set number of touch clocks
`timescale 1ns/1ps
`default_nettype none
`include "ctk_map.svh"
module ctk_pad_model (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic charge_i,
  input  wire logic discharge_i,
  input  wire logic [31:0] steps_i,
  output logic      thr_o
);
  int cyc;
  // Capacitor keeps its charge when charging stops, and empties only while discharged
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc <= 0;
    end else begin
      cyc <= discharge_i ? 0 : (charge_i ? cyc + 1 : cyc);
    end
  end
  assign thr_o = !discharge_i && cyc >= steps_i * `CTK_TICK_DIV - 1;
endmodule
`default_nettype wire

// [verif/test_capacitive_touch_sensing_controller.sv]
// Self-checking bench for the touch controller
`timescale 1ns/1ps
`default_nettype none
`include "ctk_map.svh"
module test_capacitive_touch_sensing_controller;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata, got;
  logic        wait_r, thr, rmode, rlvl, dis, chg, irq;
  logic [1:0]  cs;
  logic [12:0] pad;
  logic [2:0]  ths;
  int          bad_count = 0;
  int          checked = 0;
  int          steps = 1;
  int          n;
  int          cyc = 0;
  always #12.5 clk = ~clk;
  ctk_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .thr_reached_i(thr), .regulator_mode_o(rmode), .regulator_level_o(rlvl), .cs_pin_sel_o(cs),
    .touch_pad_select_o(pad), .threshold_sel_o(ths), .discharge_o(dis), .charge_o(chg), .irq_o(irq));
  ctk_pad_model i_pad (.core_clk_i(clk), .rst_n_i(rst_n), .charge_i(chg), .discharge_i(dis),
    .steps_i(steps), .thr_o(thr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wait_r) @(posedge clk);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One conversion: measured discharge and charge lengths, flag and count
  task automatic conv(input logic [1:0] ds, input int s);
    steps = s;
    bus(1'b1, `CTK_OFF_SET, {27'h0, 3'h2, ds});
    bus(1'b1, `CTK_OFF_CMD, {24'h0, `CTK_CMD_START});
    n = 0;
    @(negedge clk);
    while (dis && n < 600) begin
      n++;
      @(negedge clk);
    end
    chk(32'(n), (ds == 2'h0) ? 32'h80 : (ds == 2'h1) ? 32'h100 : 32'h200);
    chk(32'({chg, irq}), 32'h2);
    n = 0;
    while (chg && n < 4000) begin
      n++;
      @(negedge clk);
    end
    chk(32'(n), 32'(s * 4));
    @(negedge clk);
    chk(32'(irq), 32'h1);
    rchk(`CTK_OFF_CNTH, 32'(s >> 8));
    rchk(`CTK_OFF_CNTL, 32'(s & 255));
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rchk(6'(i * 4), 32'h0);
    $display("reset test done");
    bus(1'b1, `CTK_OFF_PWR, 32'h0000000c);
    bus(1'b1, `CTK_OFF_MISC, 32'h00000006);
    bus(1'b1, `CTK_OFF_PAD, 32'h00001000);
    @(negedge clk);
    chk(32'({rmode, rlvl, cs, pad}), 32'h1f000);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `CTK_OFF_SET, 32'(i << 2));
      @(negedge clk);
      chk(32'(ths), 32'(i));
    end
    $display("config test done");
    bus(1'b1, `CTK_OFF_MASK, 32'h48);
    conv(2'h0, 2);
    conv(2'h0, 9);
    conv(2'h1, 3);
    conv(2'h2, 1);
    bus(1'b1, `CTK_OFF_IRQ, 32'h0);
    rchk(`CTK_OFF_IRQ, 32'h0);
    conv(2'h3, 300);
    rchk(`CTK_OFF_IRQ, 32'h08);
    rchk(`CTK_OFF_IRQ, 32'h0);
    $display("conversion test done");
    bus(1'b1, `CTK_OFF_CMD, {24'h0, `CTK_CMD_HOLD});
    repeat (700) @(negedge clk);
    chk(32'({dis, chg}), 32'h2);
    steps = 50;
    bus(1'b1, `CTK_OFF_CMD, {24'h0, `CTK_CMD_START});
    @(negedge clk);
    chk(32'({dis, chg}), 32'h1);
    bus(1'b1, `CTK_OFF_CMD, {24'h0, `CTK_CMD_ABORT});
    @(negedge clk);
    chk(32'({dis, chg}), 32'h0);
    rchk(`CTK_OFF_IRQ, 32'h0);
    $display("hold test done");
    give_verdict();
  end
endmodule
`default_nettype wire
